/* File: rtl/cmw_cam_top.sv */
// cmw_cam_top: 64-word by 16-bit cam of eight cascaded 16 x 8 slices.
// assumes: classic wishbone master on sys_clk; synchronous active-high reset.
// What this block does
// - slice holds 16 words of 8 bits
// - one hit line per stored word
// - all matching words hit together
// - search completes in one match clock
// - write or erase one clock, replace two
// - match reset zeroes hits on next edge
// - write and match ports separate, but one bus request at a time
// - memory starts empty, no early hits
// - slice hit vectors concatenate for depth
// - six-bit address: two pick slice
// - lanes AND their hit lines for width
// - both ports share 4096 cells
// - cell address is data then index
// - search value addresses 16-bit read port
// - stored copy gives cell to erase
// - flag, single hit and encoded address
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module cmw_cam_top (
    input wire logic sys_clk,          // system clock, 125 MHz
    input wire logic reset,            // synchronous reset, active high
    input wire logic wb_cyc_i,         // wishbone cycle
    input wire logic wb_stb_i,         // wishbone strobe
    input wire logic wb_we_i,          // wishbone write
    input wire logic [7:0] wb_adr_i,   // wishbone byte address
    input wire logic [3:0] wb_sel_i,   // wishbone byte enables
    input wire logic [31:0] wb_dat_i,  // wishbone write data
    output logic [31:0] wb_dat_o,      // wishbone read data
    output logic wb_ack_o,             // wishbone acknowledge
    output logic [63:0] match_hit,     // hit line per word
    output logic match_flag,           // any hit
    output logic match_single,         // exactly one hit
    output logic [5:0] match_addr      // index of the single hit
);
    cmw_pkg::cmw_state_e state_ff, nxt_state;
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] cmd_ff, nxt_cmd;
    logic [15:0] skey_ff, nxt_skey;
    logic [63:0] hit_ff, nxt_hit;
    logic flag_ff, nxt_flag;
    logic single_ff, nxt_single;
    logic [5:0] maddr_ff, nxt_maddr;

    logic req;
    logic [31:0] mask;
    logic [31:0] merged;
    logic [31:0] rd_mux;
    logic wr_op;
    logic wr_bit;
    logic [15:0] wr_key;
    logic key_we;
    logic rd_en;
    logic mrst;
    logic [15:0] old_key;
    logic [63:0] hit_all;
    logic hit_any;
    logic hit_one;
    logic [5:0] hit_enc;
    logic [15:0] lane_hit [cmw_pkg::RAMS];

    cmw_ram_if ram_bus [cmw_pkg::RAMS] ();

    // one request at a time; the released cycle after ack is never taken again
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff & (state_ff == cmw_pkg::ST_IDLE);

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            mask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // write data merged into the addressed register under the byte enables
    always_comb begin
        merged = 32'h0000_0000;
        case (wb_adr_i)
            cmw_pkg::OFF_CTRL: merged = (ctrl_ff & ~mask) | (wb_dat_i & mask);
            cmw_pkg::OFF_CMD: merged = (cmd_ff & ~mask) | (wb_dat_i & mask);
            cmw_pkg::OFF_SEARCH: merged = ({16'h0000, skey_ff} & ~mask) | (wb_dat_i & mask);
            default: merged = 32'h0000_0000;
        endcase
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            cmw_pkg::OFF_CTRL: rd_mux = ctrl_ff;
            cmw_pkg::OFF_CMD: rd_mux = cmd_ff;
            cmw_pkg::OFF_SEARCH: rd_mux = {16'h0000, skey_ff};
            cmw_pkg::OFF_STATUS: begin
                rd_mux[cmw_pkg::STAT_FLAG] = flag_ff;
                rd_mux[cmw_pkg::STAT_SINGLE] = single_ff;
                rd_mux[cmw_pkg::STAT_ADDR_LSB +: 6] = maddr_ff;
            end
            cmw_pkg::OFF_HIT_LO: rd_mux = hit_ff[31:0];
            cmw_pkg::OFF_HIT_HI: rd_mux = hit_ff[63:32];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // slices side by side in depth, lanes ANDed in width
    always_comb begin
        for (int s = 0; s < cmw_pkg::SLICES; s++) begin
            hit_all[s*16 +: 16] = lane_hit[s*2] & lane_hit[s*2+1];
        end
    end

    always_comb begin
        hit_any = |hit_all;
        hit_one = hit_any & ((hit_all & (hit_all - 64'h1)) == 64'h0);
        hit_enc = 6'h00;
        // highest set bit wins; the result is only used when exactly one bit is set
        for (int i = 0; i < cmw_pkg::DEPTH; i++) begin
            if (hit_all[i]) begin
                hit_enc = 6'(i);
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_ack = 1'b0;
        nxt_dat = dat_ff;
        nxt_ctrl = ctrl_ff;
        nxt_cmd = cmd_ff;
        nxt_skey = skey_ff;
        nxt_hit = hit_ff;
        nxt_flag = flag_ff;
        nxt_single = single_ff;
        nxt_maddr = maddr_ff;
        wr_op = 1'b0;
        wr_bit = 1'b0;
        wr_key = cmd_ff[cmw_pkg::CMD_DATA_LSB +: 16];
        key_we = 1'b0;
        rd_en = 1'b0;
        mrst = 1'b0;
        case (state_ff)
            cmw_pkg::ST_IDLE: begin
                if (req && wb_we_i) begin
                    case (wb_adr_i)
                        cmw_pkg::OFF_CTRL: begin
                            // bit 2 is a pulse: never stored, so it reads back 0
                            nxt_ctrl = merged & 32'h0000_0003;
                            nxt_ack = 1'b1;
                            if (merged[cmw_pkg::CTRL_MATCH_RST]) begin
                                mrst = 1'b1;
                                nxt_hit = 64'h0;
                                nxt_flag = 1'b0;
                                nxt_single = 1'b0;
                                nxt_maddr = 6'h00;
                            end
                        end
                        cmw_pkg::OFF_CMD: begin
                            nxt_cmd = merged & 32'h033F_FFFF;
                            nxt_state = cmw_pkg::ST_OLDKEY;
                        end
                        cmw_pkg::OFF_SEARCH: begin
                            nxt_skey = merged[15:0];
                            if (ctrl_ff[cmw_pkg::CTRL_SRCH_EN]) begin
                                nxt_state = cmw_pkg::ST_SEARCH;
                            end else begin
                                nxt_ack = 1'b1;
                            end
                        end
                        default: begin
                            // status, hit and unmapped writes are ignored but still acked
                            nxt_ack = 1'b1;
                        end
                    endcase
                end else if (req) begin
                    // read data held in a register until the next read is answered
                    nxt_dat = rd_mux;
                    nxt_ack = 1'b1;
                end
            end
            cmw_pkg::ST_OLDKEY: begin
                // the copy of this word is now on the key ram output
                if (!ctrl_ff[cmw_pkg::CTRL_WR_EN]) begin
                    nxt_ack = 1'b1;
                    nxt_state = cmw_pkg::ST_IDLE;
                end else if (cmd_ff[cmw_pkg::CMD_REPLACE]) begin
                    wr_op = 1'b1;
                    wr_key = old_key;
                    nxt_state = cmw_pkg::ST_WRITE;
                end else if (cmd_ff[cmw_pkg::CMD_WRITE]) begin
                    wr_op = 1'b1;
                    wr_bit = 1'b1;
                    key_we = 1'b1;
                    nxt_ack = 1'b1;
                    nxt_state = cmw_pkg::ST_IDLE;
                end else begin
                    // erase clears the cell of the stored copy, not of the command data
                    wr_op = 1'b1;
                    wr_key = old_key;
                    nxt_ack = 1'b1;
                    nxt_state = cmw_pkg::ST_IDLE;
                end
            end
            cmw_pkg::ST_WRITE: begin
                // second clock of a replace: the old cell was cleared on the first
                wr_op = 1'b1;
                wr_bit = 1'b1;
                key_we = 1'b1;
                nxt_ack = 1'b1;
                nxt_state = cmw_pkg::ST_IDLE;
            end
            cmw_pkg::ST_SEARCH: begin
                // cell ram read data are registered, so the hits are ready one state later
                rd_en = 1'b1;
                nxt_state = cmw_pkg::ST_RESULT;
            end
            cmw_pkg::ST_RESULT: begin
                // all outputs change together so flag, single and address never disagree
                nxt_hit = hit_all;
                nxt_flag = hit_any;
                nxt_single = hit_one;
                nxt_maddr = hit_one ? hit_enc : 6'h00;
                nxt_ack = 1'b1;
                nxt_state = cmw_pkg::ST_IDLE;
            end
            default: begin
                // unused codes recover to idle rather than hang the bus
                nxt_state = cmw_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= cmw_pkg::ST_IDLE;
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            ctrl_ff <= cmw_pkg::CTRL_RESET;
            cmd_ff <= cmw_pkg::CMD_RESET;
            skey_ff <= 16'h0000;
            hit_ff <= 64'h0;
            flag_ff <= 1'b0;
            single_ff <= 1'b0;
            maddr_ff <= 6'h00;
        end else begin
            state_ff <= nxt_state;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            ctrl_ff <= nxt_ctrl;
            cmd_ff <= nxt_cmd;
            skey_ff <= nxt_skey;
            hit_ff <= nxt_hit;
            flag_ff <= nxt_flag;
            single_ff <= nxt_single;
            maddr_ff <= nxt_maddr;
        end
    end

    // the key copy is read every clock at the address of the incoming command
    // limitation: a second write without erase leaves the old value matching as well
    cmw_key_ram u_key_ram (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(key_we),
        .wr_addr(cmd_ff[cmw_pkg::CMD_ADDR_LSB +: 6]),
        .wr_data(cmd_ff[cmw_pkg::CMD_DATA_LSB +: 16]),
        .rd_addr(nxt_cmd[cmw_pkg::CMD_ADDR_LSB +: 6]),
        .rd_data(old_key)
    );

    // one cell ram per slice and lane: ram g is slice g/2, lane g%2
    genvar g;
    generate
        for (g = 0; g < cmw_pkg::RAMS; g++) begin : g_ram
            localparam logic [1:0] SLICE = 2'(g / cmw_pkg::LANES);
            localparam int LANE = g % cmw_pkg::LANES;
            // top two address bits pick the slice, low four the word
            assign ram_bus[g].wr_en = wr_op
                & (cmd_ff[cmw_pkg::CMD_ADDR_LSB + 4 +: 2] == SLICE);
            // cell address: value byte high, word index low
            assign ram_bus[g].wr_addr = {wr_key[LANE*8 +: 8],
                                         cmd_ff[cmw_pkg::CMD_ADDR_LSB +: 4]};
            assign ram_bus[g].wr_bit = wr_bit;
            assign ram_bus[g].rd_en = rd_en;
            // bus reset also clears the registered hits inside each cell ram
            assign ram_bus[g].rd_rst = mrst | reset;
            assign ram_bus[g].read_port_address = skey_ff[LANE*8 +: 8];
            assign lane_hit[g] = ram_bus[g].rd_data;
            cmw_cell_ram u_cell_ram (
                .sys_clk(sys_clk),
                .port(ram_bus[g])
            );
        end
    endgenerate

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign match_hit = hit_ff;
    assign match_flag = flag_ff;
    assign match_single = single_ff;
    assign match_addr = maddr_ff;
endmodule : cmw_cam_top

/* File: rtl/cmw_pkg.sv */
// cmw_pkg: constants, register map and state type for the 64 x 16 cam.
// assumes: shared by the top, the cell ram and the key copy ram.
package cmw_pkg;
    // one slice: 16 words of 8 bits over a 4096-cell ram
    localparam int WORDS = 16;
    localparam int KEY_W = 8;
    localparam int IDX_W = 4;
    localparam int CELL_ADDR_W = 12;
    localparam int ROWS = 256;
    // cascade: 4 slices deep, 2 lanes wide
    localparam int SLICES = 4;
    localparam int LANES = 2;
    localparam int RAMS = SLICES * LANES;
    localparam int DEPTH = 64;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_SEARCH = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_HIT_LO = 8'h10;
    localparam logic [7:0] OFF_HIT_HI = 8'h14;

    // control fields
    localparam int CTRL_WR_EN = 0;
    localparam int CTRL_SRCH_EN = 1;
    localparam int CTRL_MATCH_RST = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0003;

    // command fields
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_WRITE = 24;
    localparam int CMD_REPLACE = 25;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    // status fields
    localparam int STAT_FLAG = 0;
    localparam int STAT_SINGLE = 1;
    localparam int STAT_ADDR_LSB = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OLDKEY,
        ST_WRITE,
        ST_SEARCH,
        ST_RESULT
    } cmw_state_e;
endpackage : cmw_pkg

/* File: rtl/cmw_ram_if.sv */
// cmw_ram_if: write port and match port of one cell ram.
// assumes: both ports are sampled on the same rising clock edge.
`timescale 1ns/1ps
interface cmw_ram_if;
    logic wr_en;
    logic [11:0] wr_addr;
    logic wr_bit;
    logic rd_en;
    logic rd_rst;
    logic [7:0] read_port_address;
    logic [15:0] rd_data;
    modport ram (input wr_en, input wr_addr, input wr_bit, input rd_en, input rd_rst,
                 input read_port_address, output rd_data);
    modport user (output wr_en, output wr_addr, output wr_bit, output rd_en, output rd_rst,
                  output read_port_address, input rd_data);
endinterface : cmw_ram_if

/* File: rtl/cmw_cell_ram.sv */
// cmw_cell_ram: 4096 cells, 1-bit write port and 16-bit match port.
// assumes: a single clock; contents start empty and are not touched by reset.
`timescale 1ns/1ps
module cmw_cell_ram (
    input wire logic sys_clk, // system clock
    cmw_ram_if.ram port       // write and match port
);
    // empty at configuration, so no search hits before a write; reset leaves it alone
    logic [15:0] mem [cmw_pkg::ROWS] = '{default: 16'h0000};
    logic [15:0] rd_ff;
    logic [15:0] nxt_rd;

    // cell n sits in row n[11:4], column n[3:0]
    always_ff @(posedge sys_clk) begin
        if (port.wr_en) begin
            mem[port.wr_addr[11:4]][port.wr_addr[3:0]] <= port.wr_bit;
        end
    end

    always_comb begin
        nxt_rd = rd_ff;
        if (port.rd_rst) begin
            nxt_rd = 16'h0000;
        end else if (port.rd_en) begin
            nxt_rd = mem[port.read_port_address];
        end
    end

    always_ff @(posedge sys_clk) begin
        rd_ff <= nxt_rd;
    end

    assign port.rd_data = rd_ff;
endmodule : cmw_cell_ram

/* File: rtl/cmw_key_ram.sv */
// cmw_key_ram: copy of each stored word, read back to find the cell to erase.
// assumes: read data appear one clock after the address; read sees old data.
`timescale 1ns/1ps
module cmw_key_ram (
    input wire logic sys_clk,         // system clock
    input wire logic reset,           // sync reset of the read register
    input wire logic wr_en,           // store one word
    input wire logic [5:0] wr_addr,   // word written
    input wire logic [15:0] wr_data,  // value written
    input wire logic [5:0] rd_addr,   // word read
    output logic [15:0] rd_data       // registered read data
);
    // starts empty so an erase of a never-written word clears an already clear cell
    logic [15:0] mem [cmw_pkg::DEPTH] = '{default: 16'h0000};
    logic [15:0] rd_ff;
    logic [15:0] nxt_rd;

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_comb begin
        nxt_rd = reset ? 16'h0000 : mem[rd_addr];
    end

    always_ff @(posedge sys_clk) begin
        rd_ff <= nxt_rd;
    end

    assign rd_data = rd_ff;
endmodule : cmw_key_ram

/* File: test/cmw_cam_chk.sv */
// cmw_cam_chk: port-level checks of the cam top, bound into cmw_cam_top.
// assumes: one clock, synchronous active-high reset, classic wishbone slave.
`timescale 1ns/1ps
module cmw_cam_chk (
    input wire logic sys_clk, // system clock
    input wire logic reset, // sync reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic [63:0] match_hit, // hit lines
    input wire logic match_flag, // any hit
    input wire logic match_single, // one hit
    input wire logic [5:0] match_addr // single hit index
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic srch_en_ff;
    logic nxt_srch_en;
    logic wr_en_ff;
    logic nxt_wr_en;
    logic req;
    logic ctrl_wr;
    assign req = wb_cyc_i & wb_stb_i;
    assign ctrl_wr = wb_ack_o & wb_we_i & (wb_adr_i == cmw_pkg::OFF_CTRL) & wb_sel_i[0];
    // both enables tracked from the bus, since search and command latency depend on them
    always_comb begin
        nxt_srch_en = srch_en_ff;
        nxt_wr_en = wr_en_ff;
        if (reset) begin
            nxt_srch_en = cmw_pkg::CTRL_RESET[cmw_pkg::CTRL_SRCH_EN];
            nxt_wr_en = cmw_pkg::CTRL_RESET[cmw_pkg::CTRL_WR_EN];
        end else if (ctrl_wr) begin
            nxt_srch_en = wb_dat_i[cmw_pkg::CTRL_SRCH_EN];
            nxt_wr_en = wb_dat_i[cmw_pkg::CTRL_WR_EN];
        end
    end
    always_ff @(posedge sys_clk) begin
        srch_en_ff <= nxt_srch_en;
        wr_en_ff <= nxt_wr_en;
    end
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    read_turn_a: assert property ($rose(req && !wb_we_i) |=> wb_ack_o)
        else $error("read not answered in one cycle");
    search_time_a: assert property (
        $rose(req && wb_we_i && wb_adr_i == cmw_pkg::OFF_SEARCH) && srch_en_ff
        |=> !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("search latency wrong");
    write_time_a: assert property (
        $rose(req && wb_we_i && wb_adr_i == cmw_pkg::OFF_CMD)
        && (!wb_dat_i[cmw_pkg::CMD_REPLACE] || !wr_en_ff)
        |=> !wb_ack_o ##1 wb_ack_o) else $error("write or erase latency wrong");
    replace_time_a: assert property (
        $rose(req && wb_we_i && wb_adr_i == cmw_pkg::OFF_CMD)
        && wb_dat_i[cmw_pkg::CMD_REPLACE] && wr_en_ff
        |=> !wb_ack_o [*2] ##1 wb_ack_o) else $error("replace latency wrong");
    flag_is_or_a: assert property (match_flag == (|match_hit))
        else $error("match flag differs from or of hits");
    single_hit_a: assert property (match_single == $onehot(match_hit))
        else $error("single flag differs from one-hot test");
    single_addr_a: assert property (
        match_single ? match_hit == (64'h1 << match_addr) : match_addr == 6'h00)
        else $error("match address does not name the single hit");
    match_clear_a: assert property (
        ctrl_wr && wb_dat_i[cmw_pkg::CTRL_MATCH_RST] |-> match_hit == 64'h0 && !match_flag)
        else $error("match reset did not clear hits");
    hits_hold_a: assert property (!$stable(match_hit) |-> wb_ack_o && wb_we_i &&
        (wb_adr_i == cmw_pkg::OFF_SEARCH && srch_en_ff || wb_adr_i == cmw_pkg::OFF_CTRL))
        else $error("hits changed without a search");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h18 |->
        wb_dat_o == 32'h0) else $error("unmapped read not zero");
    cover_multi: cover property (match_flag && !match_single);
    cover_single: cover property (match_single);
    cover_clear: cover property (ctrl_wr && wb_dat_i[cmw_pkg::CTRL_MATCH_RST]);
endmodule : cmw_cam_chk

bind cmw_cam_top cmw_cam_chk u_chk (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .match_hit(match_hit),
    .match_flag(match_flag), .match_single(match_single), .match_addr(match_addr));

/* File: test/cmw_wb_master.sv */
// cmw_wb_master: user logic issuing searches and writes as a classic wishbone master.
// assumes: xfer is called just after a rising edge of sys_clk.
`timescale 1ns/1ps
module cmw_wb_master (
    input wire logic sys_clk, // system clock
    output logic cyc, // cycle
    output logic stb, // strobe
    output logic we, // write
    output logic [7:0] adr, // byte address
    output logic [3:0] sel, // byte enables
    output logic [31:0] dat, // write data
    input wire logic [31:0] rdat, // read data
    input wire logic ack // acknowledge
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
    end
    // request held until ack is sampled high; the bench timeout ends a wait with no answer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        dat <= ~d;
        @(posedge sys_clk);
    endtask : xfer
endmodule : cmw_wb_master

/* File: test/cmw_cam_tb_top.sv */
// cmw_cam_tb_top: register-level tests of the 64 x 16 cam against a word model.
// assumes: cmw_wb_master drives the bus; the checker is bound to the dut.
`timescale 1ns/1ps
module cmw_cam_tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cyc, stb, we, ack, flag, single;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat;
    logic [63:0] hit;
    logic [5:0] maddr;
    logic [15:0] keys [64];
    logic [63:0] vld = 64'h0;
    logic [63:0] hit_exp = 64'h0;
    logic wen = 1'b1;
    logic sen = 1'b1;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    always #4 sys_clk = ~sys_clk;
    cmw_wb_master bfm (.sys_clk(sys_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .sel(sel), .dat(dat), .rdat(rdat), .ack(ack));
    cmw_cam_top dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .match_hit(hit), .match_flag(flag), .match_single(single),
        .match_addr(maddr));
    task automatic test_done();
        $display("compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bfm.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [63:0] exp, input string name);
        logic [31:0] q;
        bfm.xfer(1'b0, a, 32'h0, q);
        check(name, {32'h0, q}, exp);
    endtask : rd
    // op: 01 write, 00 erase, 10 replace; the model follows only while writes are enabled
    task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] k);
        wr(cmw_pkg::OFF_CMD, {6'h00, op, 2'h0, a, k});
        if (wen && op == 2'b00) vld[a] = 1'b0;
        if (wen && op != 2'b00) begin
            vld[a] = 1'b1;
            keys[a] = k;
        end
    endtask : cmd
    task automatic search(input logic [15:0] k);
        logic [63:0] e;
        e = hit_exp;
        for (int i = 0; i < 64; i++) begin
            if (sen) e[i] = vld[i] && keys[i] === k;
        end
        hit_exp = e;
        wr(cmw_pkg::OFF_SEARCH, {16'h0, k});
        check("match_hit", hit, e);
        check("match_flag", {63'h0, flag}, {63'h0, |e});
        check("match_single", {63'h0, single}, {63'h0, $onehot(e)});
        rd(cmw_pkg::OFF_HIT_LO, {32'h0, e[31:0]}, "hit_lo");
        rd(cmw_pkg::OFF_HIT_HI, {32'h0, e[63:32]}, "hit_hi");
    endtask : search
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(cmw_pkg::OFF_CTRL, 64'h3, "ctrl");
        rd(cmw_pkg::OFF_CMD, 64'h0, "cmd");
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 64'h0, "unmapped");
        search(16'h0000);
        cmd(2'b01, 6'h03, 16'hA55A);
        cmd(2'b01, 6'h14, 16'hA55A);
        cmd(2'b01, 6'h25, 16'hA55A);
        cmd(2'b01, 6'h3F, 16'hA55A);
        cmd(2'b01, 6'h05, 16'h1234);
        cmd(2'b01, 6'h06, 16'h5634);
        search(16'hA55A);
        search(16'h1299);
        search(16'h1234);
        check("match_single", {63'h0, single}, 64'h1);
        check("match_addr", {58'h0, maddr}, 64'h5);
        rd(cmw_pkg::OFF_STATUS, 64'h503, "status");
        cmd(2'b00, 6'h14, 16'h0000);
        search(16'hA55A);
        cmd(2'b10, 6'h25, 16'h0F0F);
        search(16'hA55A);
        search(16'h0F0F);
        wen = 1'b0;
        wr(cmw_pkg::OFF_CTRL, 32'h2);
        cmd(2'b01, 6'h0A, 16'hBEEF);
        search(16'hBEEF);
        wen = 1'b1;
        wr(cmw_pkg::OFF_CTRL, 32'h3);
        search(16'hA55A);
        sen = 1'b0;
        wr(cmw_pkg::OFF_CTRL, 32'h1);
        search(16'h1234);
        sen = 1'b1;
        wr(cmw_pkg::OFF_CTRL, 32'h7);
        hit_exp = 64'h0;
        check("match_hit", hit, 64'h0);
        rd(cmw_pkg::OFF_CTRL, 64'h3, "ctrl");
        test_done();
    end
endmodule : cmw_cam_tb_top
